/* File: shared/bws_pkg.sv */
// bws_pkg: offsets, field positions and types for the window 2 setup register block
// assumes a 32-bit register port and a 64-bit window base split across two words
package bws_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] BWS_SETUP_OFF = 12'h08C;     // window2_setup
   localparam logic [11:0] BWS_BASE_LO_OFF = 12'h100;   // window base, low word
   localparam logic [11:0] BWS_BASE_HI_OFF = 12'h104;   // window base, high word
   localparam logic [11:0] BWS_STATUS_OFF = 12'h108;    // decoded window state

   // ------------------------------------------------------------
   // setup field positions and reset values
   // ------------------------------------------------------------
   localparam int BWS_SPACE_BIT = 0;
   localparam int BWS_DEC_LSB = 1;
   localparam int BWS_PREFETCHABLE_SELECT_BIT = 3;
   localparam int BWS_SIZE_LSB = 4;
   localparam int BWS_EN_BIT = 31;
   localparam logic [31:0] BWS_SETUP_RST = 32'h0000_0000;
   localparam logic [63:0] BWS_BASE_RST = 64'h0000_0000_0000_0000;

   // ------------------------------------------------------------
   // decode encodings and size limits
   // ------------------------------------------------------------
   localparam logic [1:0] BWS_NARROW_DECODE = 2'h0;
   localparam logic [1:0] BWS_WIDE_DECODE = 2'h2;
   localparam logic [5:0] BWS_SIZE_MIN = 6'h04;   // below this, except zero, the window is off
   localparam logic [5:0] BWS_SIZE_NARROW_MAX = 6'h20;
   localparam int BWS_BASE_LSB = 4;   // lowest writable base bit; base bits 3:0 are never writable

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic [5:0] size;
      logic prefetchable_select;
      logic [1:0] decode;
      logic space_select;
   } bws_setup_s;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bws_req_s;

endpackage : bws_pkg

/* File: core/bws_mask_gen.sv */
// bws_mask_gen: writable-bit mask of the 64-bit window base from the setup fields
// assumes setup fields come straight from the setup register, same clock
`timescale 1ns/1ps
`default_nettype none
module bws_mask_gen
   import bws_pkg::*;
(
   input wire bws_setup_s setup,
   output logic [63:0] wr_mask,
   output logic window_on
);

   logic [5:0] eff_size;
   logic wide;

   // effective size: narrow decoding clips sizes above 32
   always_comb begin
      wide = (setup.space_select == 1'b0) && (setup.decode == BWS_WIDE_DECODE);
      eff_size = setup.size;
      if (!wide && setup.size > BWS_SIZE_NARROW_MAX) begin
         eff_size = BWS_SIZE_NARROW_MAX;
      end
   end

   // per-bit mask: bit i of the address is writable at or above the size
   genvar gi;
   generate
      for (gi = 0; gi < 64; gi = gi + 1) begin : g_mask
         if (gi < BWS_BASE_LSB) begin : g_low
            assign wr_mask[gi] = 1'b0;
         end else begin : g_hi
            assign wr_mask[gi] = setup.enable && window_on && (wide || gi < 32) &&
                                 ((setup.size == 6'h00) || (gi >= eff_size));
         end
      end
   endgenerate

   // zero size means whole space; 1..3 disables the window
   assign window_on = (setup.size == 6'h00) || (setup.size >= BWS_SIZE_MIN);

endmodule : bws_mask_gen
`default_nettype wire

/* File: core/bws_read_mux.sv */
// bws_read_mux: read-data selection for the register port
// assumes the caller registers the result for the one-cycle-late read data
`timescale 1ns/1ps
`default_nettype none
module bws_read_mux
   import bws_pkg::*;
(
   input wire logic [11:0] addr,
   input wire logic [31:0] setup_word,
   input wire logic [63:0] base_view,
   input wire logic [31:0] status_word,
   output logic [31:0] rdata
);

   // unmapped addresses read as zero
   always_comb begin
      unique case (addr)
         BWS_SETUP_OFF: rdata = setup_word;
         BWS_BASE_LO_OFF: rdata = base_view[31:0];
         BWS_BASE_HI_OFF: rdata = base_view[63:32];
         BWS_STATUS_OFF: rdata = status_word;
         default: rdata = 32'h0000_0000;
      endcase
   end

endmodule : bws_read_mux
`default_nettype wire

/* File: core/bws_window_setup.sv */
// bws_window_setup: window 2 setup register and the window base it shapes
// assumes a simple register port; read data valid one cycle after the read strobe
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module bws_window_setup
   import bws_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic window_enabled,
   output logic window_io,
   output logic window_wide,
   output logic window_prefetchable,
   output logic [63:0] window_base,
   output logic [63:0] window_mask
);

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------

   // true when the request writes the register at the given offset
   function automatic logic write_hit(input bws_req_s r, input logic [11:0] off);
      return r.wr && (r.addr == off);
   endfunction : write_hit

   // unpack a setup word; I/O space forces the decode field to zero
   function automatic bws_setup_s setup_from_word(input logic [31:0] w);
      bws_setup_s s;
      s.space_select = w[BWS_SPACE_BIT];
      s.decode = w[BWS_DEC_LSB +: 2];
      s.prefetchable_select = w[BWS_PREFETCHABLE_SELECT_BIT];
      s.size = w[BWS_SIZE_LSB +: 6];
      s.enable = w[BWS_EN_BIT];
      if (w[BWS_SPACE_BIT]) begin
         s.decode = BWS_NARROW_DECODE;
      end
      return s;
   endfunction : setup_from_word

   // pack the setup fields into a word; reserved bits 30:10 read zero
   function automatic logic [31:0] setup_to_word(input bws_setup_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[BWS_SPACE_BIT] = s.space_select;
      w[BWS_DEC_LSB +: 2] = s.decode;
      w[BWS_PREFETCHABLE_SELECT_BIT] = s.prefetchable_select;
      w[BWS_SIZE_LSB +: 6] = s.size;
      w[BWS_EN_BIT] = s.enable;
      return w;
   endfunction : setup_to_word

   // low nibble of the base view: space, decode type and prefetch flags
   function automatic logic [3:0] type_bits(input bws_setup_s s);
      logic [3:0] t;
      t = 4'h0;
      t[BWS_SPACE_BIT] = s.space_select;
      t[BWS_DEC_LSB +: 2] = s.decode;
      t[BWS_PREFETCHABLE_SELECT_BIT] = s.prefetchable_select;
      return t;
   endfunction : type_bits

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // power-on value only: no reset input, so the fields ride through every reset
   bws_setup_s setup_r = setup_from_word(BWS_SETUP_RST);
   bws_setup_s setup_nxt;
   logic [63:0] base_r;
   logic [63:0] base_nxt;
   logic [63:0] wr_mask;
   logic win_on;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [31:0] setup_word;
   logic [63:0] base_view;
   logic [31:0] status_word;
   bws_req_s req;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ------------------------------------------------------------
   // setup register
   // ------------------------------------------------------------

   // next setup value: a write replaces every field at once
   // in memory space, reserved decode codes are kept as written and act as narrow decoding
   // window size limits are not checked here; software keeps them legal
   always_comb begin
      setup_nxt = setup_r;
      if (write_hit(req, BWS_SETUP_OFF)) begin
         setup_nxt = setup_from_word(req.wdata);
      end
   end

   // srst is the system's fundamental or hot reset; setup keeps its value across it
   always_ff @(posedge sys_clk) begin
      setup_r <= setup_nxt;
   end

   // ------------------------------------------------------------
   // writable mask
   // ------------------------------------------------------------
   bws_mask_gen u_mask (
      .setup(setup_r),
      .wr_mask(wr_mask),
      .window_on(win_on)
   );

   // ------------------------------------------------------------
   // window base register
   // ------------------------------------------------------------

   // one slice per base word: low word holds address bits 31:0, high word 63:32
   // only masked bits take write data; the rest fall to zero when the mask shrinks
   // a base write uses the mask in force that cycle, as setup and base never share a write
   genvar gw;
   generate
      for (gw = 0; gw < 2; gw = gw + 1) begin : g_base_word
         logic hit;
         logic [31:0] keep;
         logic [31:0] load;
         assign hit = write_hit(req, (gw == 0) ? BWS_BASE_LO_OFF : BWS_BASE_HI_OFF);
         assign keep = base_r[gw*32 +: 32] & wr_mask[gw*32 +: 32];
         assign load = req.wdata & wr_mask[gw*32 +: 32];
         assign base_nxt[gw*32 +: 32] = hit ? load : keep;
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         base_r <= BWS_BASE_RST;
      end else begin
         base_r <= base_nxt;
      end
   end

   // ------------------------------------------------------------
   // read views
   // ------------------------------------------------------------

   // setup word: reserved bits 30:10 read zero
   assign setup_word = setup_to_word(setup_r);

   // base view: while enable is set, low bits carry space, type and prefetch, like a base register; otherwise all zero
   always_comb begin
      base_view = base_r & wr_mask;
      base_view[3:0] = type_bits(setup_r);
      if (!setup_r.enable) begin
         base_view = 64'h0000_0000_0000_0000;
      end
   end

   // status word: decoded state of the window
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[0] = setup_r.enable && win_on;
      status_word[1] = window_wide;
   end

   bws_read_mux u_rmux (
      .addr(req.addr),
      .setup_word(setup_word),
      .base_view(base_view),
      .status_word(status_word),
      .rdata(rdata_nxt)
   );

   // read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_r <= 32'h0000_0000;
      end else if (req.rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = rdata_r;
   assign window_enabled = setup_r.enable && win_on;
   assign window_io = setup_r.space_select;
   assign window_wide = !setup_r.space_select && setup_r.decode == BWS_WIDE_DECODE;
   assign window_prefetchable = setup_r.prefetchable_select;
   assign window_base = base_r & wr_mask;
   assign window_mask = wr_mask;

endmodule : bws_window_setup
`default_nettype wire

/* File: tb/bws_chk.sv */
// bws_chk: port assertions for the window setup block
// assumes bind from tb_top, one clock sys_clk
`timescale 1ns/1ps
`default_nettype none
module bws_chk
   import bws_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic window_enabled,
   input wire logic window_io,
   input wire logic window_wide,
   input wire logic window_prefetchable,
   input wire logic [63:0] window_base,
   input wire logic [63:0] window_mask
);
   // ----------------------------------------
   // shadow of setup writes, kept across srst
   // ----------------------------------------
   logic [31:0] sh_r = 32'h0000_0000;
   always_ff @(posedge sys_clk) begin
      if (reg_wr && reg_addr == BWS_SETUP_OFF) begin
         sh_r <= reg_wdata;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   a_space_follows: assert property (window_io == sh_r[0])
      else $error("space flag wrong");
   a_wide_decode: assert property (window_wide == (!sh_r[0] && sh_r[2:1] == 2'h2))
      else $error("wide flag wrong");
   a_prefetchable_select_follows: assert property (window_prefetchable == sh_r[3])
      else $error("prefetch flag wrong");
   a_enable_rule: assert property (window_enabled == (sh_r[31] && !(sh_r[9:4] inside {[1:3]})))
      else $error("enable flag wrong");
   a_mask_nibble: assert property (window_mask[3:0] == 4'h0)
      else $error("mask covers low nibble");
   a_narrow_upper: assert property (!window_wide |-> window_mask[63:32] == 32'h0000_0000)
      else $error("narrow mask reaches upper word");
   a_base_write: assert property (reg_wr && reg_addr == BWS_BASE_LO_OFF |=>
      window_base[31:0] == ($past(reg_wdata) & window_mask[31:0]))
      else $error("base write not masked");
   a_size_edge: assert property (sh_r[31] && sh_r[9:4] inside {[4:31]} |->
      window_mask[sh_r[9:4]] && !window_mask[sh_r[9:4] - 6'h01])
      else $error("mask edge not at size");
   a_off_clear: assert property (sh_r[9:4] inside {[1:3]} |-> window_mask == 0)
      else $error("small size leaves mask");
   // main scenarios
   cover property (window_wide && window_enabled);
   cover property (window_io && window_enabled);
   cover property (sh_r[31] && !window_enabled);
endmodule : bws_chk
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: register-port tests of the window setup block
// assumes 10 MHz sys_clk, checker bound below
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import bws_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic window_enabled, window_io, window_wide, window_prefetchable;
   logic [63:0] window_base, window_mask;
   int errors = 0;
   int n_compared = 0;
   logic [31:0] w [6] = '{32'h8000_0070, 32'h8000_0244, 32'h8000_0004, 32'h8000_0030,
      32'h8000_0041, 32'h8000_0280};
   logic [63:0] m [6] = '{64'h0000_0000_FFFF_FF80, 64'hFFFF_FFF0_0000_0000,
      64'hFFFF_FFFF_FFFF_FFF0, 64'h0, 64'h0000_0000_FFFF_FFF0, 64'h0};
   logic [63:0] c [6] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF,
      64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF,
      64'hFFFF_FFFF_FFFF_FFFF};
   logic [2:0] f [6] = '{3'h4, 3'h5, 3'h5, 3'h0, 3'h6, 3'h4};
   always #50 sys_clk = ~sys_clk;
   bws_window_setup i_bws_window_setup (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .window_enabled(window_enabled), .window_io(window_io), .window_wide(window_wide),
      .window_prefetchable(window_prefetchable), .window_base(window_base),
      .window_mask(window_mask));
   // compare and count
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   // one-cycle write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // read, data checked in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      cmp({32'h0, reg_rdata}, {32'h0, e});
   endtask : rd
   task automatic complete_run;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   // watchdog
   initial begin
      #200000;
      errors++;
      complete_run();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      rd(BWS_SETUP_OFF, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(BWS_SETUP_OFF, w[i]);
         cmp(window_mask & c[i], m[i] & c[i]);
         cmp({61'h0, window_enabled, window_io, window_wide}, {61'h0, f[i]});
         rd(BWS_SETUP_OFF, w[i]);
      end
      wr(BWS_SETUP_OFF, 32'h8000_0045);
      rd(BWS_SETUP_OFF, 32'h8000_0041);
      wr(BWS_SETUP_OFF, 32'h8000_0070);
      wr(BWS_BASE_LO_OFF, 32'hFFFF_FFFF);
      wr(BWS_BASE_HI_OFF, 32'hFFFF_FFFF);
      rd(BWS_BASE_LO_OFF, 32'hFFFF_FF80);
      rd(BWS_BASE_HI_OFF, 32'h0);
      wr(BWS_SETUP_OFF, 32'h8000_004C);
      wr(BWS_BASE_HI_OFF, 32'hFFFF_FFFF);
      rd(BWS_BASE_HI_OFF, 32'hFFFF_FFFF);
      rd(BWS_BASE_LO_OFF, 32'hFFFF_FF8C);
      cmp(window_base, 64'hFFFF_FFFF_FFFF_FF80);
      cmp({63'h0, window_prefetchable}, 64'h1);
      rd(BWS_STATUS_OFF, 32'h0000_0003);
      wr(BWS_SETUP_OFF, 32'h0000_004C);
      rd(BWS_BASE_LO_OFF, 32'h0);
      rd(BWS_STATUS_OFF, 32'h0000_0002);
      wr(12'h200, 32'hFFFF_FFFF);
      rd(12'h200, 32'h0);
      rd(BWS_SETUP_OFF, 32'h0000_004C);
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      rd(BWS_SETUP_OFF, 32'h0000_004C);
      complete_run();
   end
endmodule : tb_top
bind bws_window_setup bws_chk i_bws_chk (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .window_enabled(window_enabled), .window_io(window_io), .window_wide(window_wide),
   .window_prefetchable(window_prefetchable), .window_base(window_base),
   .window_mask(window_mask));
`default_nettype wire
